//--- hdl/elcb_pkg.sv
// shared constants and types of the expanded line configuration bank
package elcb_pkg;
    localparam int NUM_CHAN = 8;
    localparam int ADDR_W = 5;
    // expanded bank offsets
    localparam logic [4:0] OFS_SINGLE_RAIL = 5'h00;
    localparam logic [4:0] OFS_LINE_CODE = 5'h01;
    localparam logic [4:0] OFS_RECOVERY_DIS = 5'h02;
    localparam logic [4:0] OFS_RX_POWERDOWN = 5'h03;
    localparam logic [4:0] OFS_TX_POWERDOWN = 5'h04;
    localparam logic [4:0] OFS_ZERO_DETECT = 5'h05;
    localparam logic [4:0] OFS_VIOL_DISABLE = 5'h06;
    localparam logic [4:0] OFS_EQUALIZER = 5'h07;
    localparam logic [4:0] OFS_LOOP_CONFIG = 5'h08;
    localparam logic [4:0] OFS_ACT_PATTERN = 5'h09;
    // bank pointer sits at the same offset in both banks
    localparam logic [4:0] OFS_BANK_POINTER = 5'h1F;
    localparam logic [7:0] BANK_PTR_PRIMARY = 8'h00;
    localparam logic [7:0] BANK_PTR_EXPANDED = 8'hAA;
    // reset values
    localparam logic [7:0] RST_CHAN_REG = 8'h00;
    localparam logic [5:0] RST_LOOP_CONFIG = 6'h00;
    localparam logic [7:0] RST_ACT_PATTERN = 8'h00;
    // loop configuration field positions
    localparam int LCF_DETECT_EN = 5;
    localparam int LCF_AUTO_EN = 4;
    localparam int LCF_ACT_LEN_LSB = 2;
    localparam int LCF_DEACT_LEN_LSB = 0;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TX_CLK_LOW_NS = 2000;
    localparam int TX_CLK_LOW_CYC = (TX_CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOOP_REPEAT = 4;

    typedef struct packed {
        logic [7:0] singleRail;
        logic [7:0] amiCode;
        logic [7:0] recoveryOff;
        logic [7:0] rxPowerdown;
        logic [7:0] txPowerdown;
        logic [7:0] zeroDetect;
        logic [7:0] violationDetect;
        logic [7:0] equalizer;
    } elcb_chan_cfg_s;

    // effective-bit mask for a two-bit code length field: 5,6,7,8 bits from the msb
    function automatic logic [7:0] elcb_len_mask(input logic [1:0] len);
        logic [7:0] m;
        m = 8'hFF;
        case (len)
            2'h0: m = 8'hF8;
            2'h1: m = 8'hFC;
            2'h2: m = 8'hFE;
            default: m = 8'hFF;
        endcase
        return m;
    endfunction : elcb_len_mask
endpackage : elcb_pkg

//--- hdl/elcb_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module elcb_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : elcb_sync

//--- hdl/elcb_loop_detector.sv
// repeating loopback code detector for one channel
`timescale 1ns/1ps
module elcb_loop_detector #(
    parameter int REPEAT = elcb_pkg::LOOP_REPEAT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // received single-rail bit stream
    input wire logic bitValid,
    input wire logic bitData,
    // global configuration
    input wire logic detectEnable,
    input wire logic [7:0] actPattern,
    input wire logic [1:0] actLength,
    input wire logic [7:0] deactPattern,
    input wire logic [1:0] deactLength,
    // result
    output logic detectStatus_q
);
    import elcb_pkg::*;

    logic [7:0] hist_q;
    logic [3:0] fill_q;
    logic [3:0] actGap_q;
    logic [3:0] deactGap_q;
    logic [3:0] actCnt_q;
    logic [3:0] deactCnt_q;
    wire histFull = (fill_q == 4'h8);
    // the eighth strobed bit completes the first window, so compare from there on
    wire winReady = (fill_q >= 4'h7);
    wire [7:0] histNext = {hist_q[6:0], bitData};
    // only the effective code bits take part in the compare
    wire actMatch = winReady && (((histNext ^ actPattern) & elcb_len_mask(actLength)) == 8'h00);
    wire deactMatch = winReady && (((histNext ^ deactPattern) & elcb_len_mask(deactLength)) == 8'h00);
    // a match must recur within one window, else the run is broken
    wire actBroken = (actGap_q == 4'h8);
    wire deactBroken = (deactGap_q == 4'h8);
    wire actDone = actMatch && (actCnt_q == 4'(REPEAT - 1));
    wire deactDone = deactMatch && (deactCnt_q == 4'(REPEAT - 1));

    // history and run counters; fill count and run counts held clear while detection is off
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hist_q <= 8'h00;
            fill_q <= 4'h0;
            actGap_q <= 4'h0;
            deactGap_q <= 4'h0;
            actCnt_q <= 4'h0;
            deactCnt_q <= 4'h0;
            detectStatus_q <= 1'b0;
        end
        else if (!detectEnable)
        begin
            fill_q <= 4'h0;
            actCnt_q <= 4'h0;
            deactCnt_q <= 4'h0;
            detectStatus_q <= 1'b0;
        end
        else if (bitValid)
        begin
            hist_q <= histNext;
            fill_q <= histFull ? fill_q : fill_q + 4'h1;
            actGap_q <= actMatch ? 4'h0 : (actBroken ? actGap_q : actGap_q + 4'h1);
            deactGap_q <= deactMatch ? 4'h0 : (deactBroken ? deactGap_q : deactGap_q + 4'h1);
            actCnt_q <= actDone ? 4'h0 : (actMatch ? actCnt_q + 4'h1 : (actBroken ? 4'h0 : actCnt_q));
            deactCnt_q <= deactDone ? 4'h0 : (deactMatch ? deactCnt_q + 4'h1 : (deactBroken ? 4'h0 : deactCnt_q));
            if (actDone)
                detectStatus_q <= 1'b1;
            else if (deactDone)
                detectStatus_q <= 1'b0;
        end
    end
endmodule : elcb_loop_detector

//--- hdl/elcb_bank.sv
// expanded configuration register bank of the eight-channel line interface
`timescale 1ns/1ps
// How it works
// - single-rail bit forces single rail with recovery on, dual rail with it off; clear, pin
// - line-code bit: 0 B8ZS/HDB3, 1 AMI
// - recovery bit 1 disables clock recovery
// - receiver powerdown bit powers receiver down
// - transmitter powerdown bit: driver low-power high-Z
// - transmit clock held low also powers down
// - zero-detect bit enables excessive-zeros detection
// - violation bit inverted: 0 enables detection
// - equalizer bit enables receive equalizer
// - config bit 5 enables loopback detection
// - config bit 4 enables automatic loopback
// - bits 3-2 choose activate code length
// - bits 1-0 choose deactivate code length
// - activation pattern register holds repeating code
// - loop config and pattern are global
// - bit n controls channel n only
// - bank pointer AAH selects expanded bank
// - status change sets interrupt bit if enabled
module elcb_bank #(
    parameter int NCH = elcb_pkg::NUM_CHAN,
    parameter int TX_LOW_CYC = elcb_pkg::TX_CLK_LOW_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // host interface
    input wire logic [elcb_pkg::ADDR_W-1:0] hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic hostWrEn,
    input wire logic hostRdEn,
    output logic [7:0] hostRdData_q,
    output logic [7:0] bankPointer_q,
    // line pins
    input wire logic [NCH-1:0] tx_negative_pin,
    input wire logic [NCH-1:0] tx_clock_pin,
    // recovered receive data, one strobe per bit
    input wire logic [NCH-1:0] rxBitValid,
    input wire logic [NCH-1:0] rxBitData,
    // neighbouring loopback registers
    input wire logic [7:0] deactivate_pattern,
    input wire logic [NCH-1:0] loop_irq_mask,
    input wire logic loopIrqClear,
    // channel controls
    output elcb_pkg::elcb_chan_cfg_s chanCfg_q,
    output logic [NCH-1:0] loop_detect_status_q,
    output logic [NCH-1:0] loop_irq_status_q,
    output logic [NCH-1:0] autoLoopback_q
);
    import elcb_pkg::*;

    logic [7:0] single_rail_bits_q;
    logic [7:0] lineCodeBits_q;
    logic [7:0] recovery_disable_bits_q;
    logic [7:0] rx_powerdown_bits_q;
    logic [7:0] tx_powerdown_bits_q;
    logic [7:0] zero_detect_bits_q;
    logic [7:0] violation_disable_bits_q;
    logic [7:0] equalizer_bits_q;
    logic [5:0] loopback_config_q;
    logic [7:0] activate_pattern_q;
    logic [NCH-1:0] txNegSync;
    logic [NCH-1:0] txClkSync;
    logic [NCH-1:0] txClkStuck;
    logic [NCH-1:0] detStatus;

    // bank selection and write decode
    wire expandedSel = (bankPointer_q == BANK_PTR_EXPANDED);
    wire wrPtr = hostWrEn && (hostAddr == OFS_BANK_POINTER);
    wire wrExp = hostWrEn && expandedSel;
    wire wrSingle = wrExp && (hostAddr == OFS_SINGLE_RAIL);
    wire wrCode = wrExp && (hostAddr == OFS_LINE_CODE);
    wire wrRecov = wrExp && (hostAddr == OFS_RECOVERY_DIS);
    wire wrRxPd = wrExp && (hostAddr == OFS_RX_POWERDOWN);
    wire wrTxPd = wrExp && (hostAddr == OFS_TX_POWERDOWN);
    wire wrZero = wrExp && (hostAddr == OFS_ZERO_DETECT);
    wire wrViol = wrExp && (hostAddr == OFS_VIOL_DISABLE);
    wire wrEqu = wrExp && (hostAddr == OFS_EQUALIZER);
    wire wrLoopCfg = wrExp && (hostAddr == OFS_LOOP_CONFIG);
    wire wrActPat = wrExp && (hostAddr == OFS_ACT_PATTERN);

    // global loopback fields
    wire detectEnable = loopback_config_q[LCF_DETECT_EN];
    wire autoEnable = loopback_config_q[LCF_AUTO_EN];
    wire [1:0] actLength = loopback_config_q[LCF_ACT_LEN_LSB+:2];
    wire [1:0] deactLength = loopback_config_q[LCF_DEACT_LEN_LSB+:2];

    // read selection; other offsets of the expanded bank read zero
    wire [7:0] expRead =
        (hostAddr == OFS_SINGLE_RAIL) ? single_rail_bits_q :
        (hostAddr == OFS_LINE_CODE) ? lineCodeBits_q :
        (hostAddr == OFS_RECOVERY_DIS) ? recovery_disable_bits_q :
        (hostAddr == OFS_RX_POWERDOWN) ? rx_powerdown_bits_q :
        (hostAddr == OFS_TX_POWERDOWN) ? tx_powerdown_bits_q :
        (hostAddr == OFS_ZERO_DETECT) ? zero_detect_bits_q :
        (hostAddr == OFS_VIOL_DISABLE) ? violation_disable_bits_q :
        (hostAddr == OFS_EQUALIZER) ? equalizer_bits_q :
        (hostAddr == OFS_LOOP_CONFIG) ? {2'b00, loopback_config_q} :
        (hostAddr == OFS_ACT_PATTERN) ? activate_pattern_q : 8'h00;
    wire [7:0] rdSel = (hostAddr == OFS_BANK_POINTER) ? bankPointer_q : (expandedSel ? expRead : 8'h00);

    // pin levels cross into ref_clk before use
    elcb_sync #(.WIDTH(2 * NCH)) u_pin_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .asyncIn({tx_negative_pin, tx_clock_pin}),
        .syncOut({txNegSync, txClkSync})
    );

    // register writes; bits 7-6 of the loop config are not stored, software keeps them zero
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bankPointer_q <= BANK_PTR_PRIMARY;
            single_rail_bits_q <= RST_CHAN_REG;
            lineCodeBits_q <= RST_CHAN_REG;
            recovery_disable_bits_q <= RST_CHAN_REG;
            rx_powerdown_bits_q <= RST_CHAN_REG;
            tx_powerdown_bits_q <= RST_CHAN_REG;
            zero_detect_bits_q <= RST_CHAN_REG;
            violation_disable_bits_q <= RST_CHAN_REG;
            equalizer_bits_q <= RST_CHAN_REG;
            loopback_config_q <= RST_LOOP_CONFIG;
            activate_pattern_q <= RST_ACT_PATTERN;
        end
        else
        begin
            if (wrPtr) bankPointer_q <= hostWrData;
            if (wrSingle) single_rail_bits_q <= hostWrData;
            if (wrCode) lineCodeBits_q <= hostWrData;
            if (wrRecov) recovery_disable_bits_q <= hostWrData;
            if (wrRxPd) rx_powerdown_bits_q <= hostWrData;
            if (wrTxPd) tx_powerdown_bits_q <= hostWrData;
            if (wrZero) zero_detect_bits_q <= hostWrData;
            if (wrViol) violation_disable_bits_q <= hostWrData;
            if (wrEqu) equalizer_bits_q <= hostWrData;
            if (wrLoopCfg) loopback_config_q <= hostWrData[5:0];
            if (wrActPat) activate_pattern_q <= hostWrData;
        end
    end

    // read data answers one cycle after the strobe and then holds
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            hostRdData_q <= 8'h00;
        else if (hostRdEn)
            hostRdData_q <= rdSel;
    end

    // per-channel logic: bit n of every channel register drives channel n only
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_chan
            logic [15:0] lowCnt_q;
            wire recoveryOn = !recovery_disable_bits_q[ch];
            // register set forces single rail with recovery on and dual rail with it off; register clear, the pin decides (high = single)
            wire singleMode = single_rail_bits_q[ch] ? recoveryOn : txNegSync[ch];
            wire singleDec = singleMode && recoveryOn;
            wire statusChange = detStatus[ch] != loop_detect_status_q[ch];
            // a clock stuck low for the whole window counts as missing
            assign txClkStuck[ch] = (lowCnt_q == 16'(TX_LOW_CYC));

            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                    lowCnt_q <= 16'h0000;
                else if (txClkSync[ch])
                    lowCnt_q <= 16'h0000;
                else if (!txClkStuck[ch])
                    lowCnt_q <= lowCnt_q + 16'h0001;
            end

            // decoded controls, all registered
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    chanCfg_q.singleRail[ch] <= 1'b0;
                    chanCfg_q.amiCode[ch] <= 1'b0;
                    chanCfg_q.recoveryOff[ch] <= 1'b0;
                    chanCfg_q.rxPowerdown[ch] <= 1'b0;
                    chanCfg_q.txPowerdown[ch] <= 1'b0;
                    chanCfg_q.zeroDetect[ch] <= 1'b0;
                    chanCfg_q.violationDetect[ch] <= 1'b0;
                    chanCfg_q.equalizer[ch] <= 1'b0;
                end
                else
                begin
                    chanCfg_q.singleRail[ch] <= singleMode;
                    chanCfg_q.amiCode[ch] <= lineCodeBits_q[ch] && singleDec;
                    chanCfg_q.recoveryOff[ch] <= !recoveryOn;
                    chanCfg_q.rxPowerdown[ch] <= rx_powerdown_bits_q[ch];
                    chanCfg_q.txPowerdown[ch] <= tx_powerdown_bits_q[ch] || txClkStuck[ch];
                    chanCfg_q.zeroDetect[ch] <= zero_detect_bits_q[ch] && singleDec && !lineCodeBits_q[ch];
                    chanCfg_q.violationDetect[ch] <= !violation_disable_bits_q[ch] && singleDec
                        && !lineCodeBits_q[ch];
                    chanCfg_q.equalizer[ch] <= equalizer_bits_q[ch];
                end
            end

            elcb_loop_detector #(.REPEAT(LOOP_REPEAT)) u_det (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .bitValid(rxBitValid[ch]),
                .bitData(rxBitData[ch]),
                .detectEnable(detectEnable),
                .actPattern(activate_pattern_q),
                .actLength(actLength),
                .deactPattern(deactivate_pattern),
                .deactLength(deactLength),
                .detectStatus_q(detStatus[ch])
            );

            // status, sticky interrupt bit (set beats clear) and auto loopback
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    loop_detect_status_q[ch] <= 1'b0;
                    loop_irq_status_q[ch] <= 1'b0;
                    autoLoopback_q[ch] <= 1'b0;
                end
                else
                begin
                    loop_detect_status_q[ch] <= detStatus[ch];
                    if (statusChange && loop_irq_mask[ch] && detectEnable)
                        loop_irq_status_q[ch] <= 1'b1;
                    else if (loopIrqClear)
                        loop_irq_status_q[ch] <= 1'b0;
                    autoLoopback_q[ch] <= autoEnable && detStatus[ch];
                end
            end
        end
    endgenerate

    property p_bank_gate;
        @(posedge ref_clk) disable iff (!nrst)
        (hostWrEn && hostAddr == OFS_RX_POWERDOWN && !expandedSel) |=> $stable(rx_powerdown_bits_q);
    endproperty
    a_bank_gate: assert property (p_bank_gate) else $error("write reached expanded bank while primary selected");

    property p_ptr_write;
        @(posedge ref_clk) disable iff (!nrst)
        wrPtr |=> (bankPointer_q == $past(hostWrData));
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("bank pointer did not take written value");

    property p_rd_answer;
        @(posedge ref_clk) disable iff (!nrst)
        (hostRdEn && expandedSel && hostAddr == OFS_ACT_PATTERN && !hostWrEn) |=> (hostRdData_q == activate_pattern_q);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("activation pattern read back wrong");

    property p_cfg_hi_zero;
        @(posedge ref_clk) disable iff (!nrst)
        (hostRdEn && expandedSel && hostAddr == OFS_LOOP_CONFIG) |=> (hostRdData_q[7:6] == 2'b00);
    endproperty
    a_cfg_hi_zero: assert property (p_cfg_hi_zero) else $error("loop config reserved bits not zero");

    property p_tx_pd;
        @(posedge ref_clk) disable iff (!nrst)
        (tx_powerdown_bits_q[0] || txClkStuck[0]) |=> chanCfg_q.txPowerdown[0];
    endproperty
    a_tx_pd: assert property (p_tx_pd) else $error("transmitter not powered down");

    wire [15:0] lowCnt0 = g_chan[0].lowCnt_q;
    property p_tx_stuck;
        @(posedge ref_clk) disable iff (!nrst)
        (!txClkSync[0] && lowCnt0 == 16'(TX_LOW_CYC - 1)) |=> txClkStuck[0];
    endproperty
    a_tx_stuck: assert property (p_tx_stuck) else $error("low transmit clock not flagged in time");

    property p_ami_gate;
        @(posedge ref_clk) disable iff (!nrst)
        chanCfg_q.amiCode[1] |-> ($past(lineCodeBits_q[1]) && !$past(recovery_disable_bits_q[1]));
    endproperty
    a_ami_gate: assert property (p_ami_gate) else $error("line code applied outside single rail");

    property p_single_force;
        @(posedge ref_clk) disable iff (!nrst)
        (single_rail_bits_q[2] && !recovery_disable_bits_q[2]) ##1 $stable(single_rail_bits_q[2])
            |-> chanCfg_q.singleRail[2];
    endproperty
    a_single_force: assert property (p_single_force) else $error("single rail not forced");

    property p_viol_sense;
        @(posedge ref_clk) disable iff (!nrst)
        violation_disable_bits_q[3] |=> !chanCfg_q.violationDetect[3];
    endproperty
    a_viol_sense: assert property (p_viol_sense) else $error("violation detect not disabled");

    property p_irq_set;
        @(posedge ref_clk) disable iff (!nrst)
        (detStatus[2] != loop_detect_status_q[2] && loop_irq_mask[2] && detectEnable) |=> loop_irq_status_q[2];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("loop interrupt bit not set");

    property p_det_off;
        @(posedge ref_clk) disable iff (!nrst)
        // detector clears on the first low edge, the status register one edge later
        !detectEnable [*3] |-> (loop_detect_status_q == '0);
    endproperty
    a_det_off: assert property (p_det_off) else $error("detect status while detection disabled");

    property p_auto;
        @(posedge ref_clk) disable iff (!nrst)
        autoLoopback_q[2] |-> $past(autoEnable);
    endproperty
    a_auto: assert property (p_auto) else $error("auto loopback without enable");

    c_expanded: cover property (@(posedge ref_clk) disable iff (!nrst) wrPtr && hostWrData == BANK_PTR_EXPANDED);
    c_loop_up: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(loop_detect_status_q[2]));
    c_loop_down: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(loop_detect_status_q[2]));
    c_clk_stuck: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(txClkStuck[0]));
endmodule : elcb_bank

//--- dv/tb.sv
// self-checking bench of the expanded line configuration bank
`timescale 1ns/1ps
module tb;
    import elcb_pkg::*;
    localparam int TXLOW = 20;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] hostAddr = 5'h00;
    logic [7:0] hostWrData = 8'h00;
    logic hostWrEn = 1'b0;
    logic hostRdEn = 1'b0;
    logic [7:0] txNeg = 8'h00;
    logic [7:0] txClk = 8'hFF;
    logic [7:0] rxV = 8'h00;
    logic [7:0] rxD = 8'h00;
    logic irqClr = 1'b0;
    logic rdLate = 1'b0;
    logic [7:0] rdData, bankPtr, lds, lis, alb;
    elcb_chan_cfg_s cfg;
    logic [7:0] rg [0:9];
    logic [7:0] rdQ [$];
    logic [15:0] lfsr = 16'h0863;
    int n_errors = 0;
    int total_checks = 0;

    elcb_bank #(.TX_LOW_CYC(TXLOW)) elcb_bank_i (.ref_clk(ref_clk), .nrst(nrst), .hostAddr(hostAddr),
        .hostWrData(hostWrData), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostRdData_q(rdData),
        .bankPointer_q(bankPtr), .tx_negative_pin(txNeg), .tx_clock_pin(txClk), .rxBitValid(rxV),
        .rxBitData(rxD), .deactivate_pattern(8'h3C), .loop_irq_mask(8'h04), .loopIrqClear(irqClr),
        .chanCfg_q(cfg), .loop_detect_status_q(lds), .loop_irq_status_q(lis), .autoLoopback_q(alb));

    // free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    // derived controls from the bench's own register copy; recovery off overrides single rail
    function automatic elcb_chan_cfg_s expCfg(input logic [7:0] stuck);
        logic [7:0] sr;
        logic [7:0] ok;
        sr = (rg[0] & ~rg[2]) | (~rg[0] & txNeg);
        ok = sr & ~rg[2];
        return '{sr, rg[1] & ok, rg[2], rg[3], rg[4] | stuck, rg[5] & ok & ~rg[1], ~rg[6] & ok & ~rg[1], rg[7]};
    endfunction : expCfg

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        hostAddr = a;
        hostWrData = d;
        hostWrEn = 1'b1;
        @(negedge ref_clk);
        hostWrEn = 1'b0;
    endtask : wr

    // the expected value is queued now and compared when the answer appears
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        rdQ.push_back(e);
        @(negedge ref_clk);
        hostAddr = a;
        hostRdEn = 1'b1;
        @(negedge ref_clk);
        hostRdEn = 1'b0;
    endtask : rd

    // msb first, one bit per cycle on the selected channels
    task automatic send(input logic [7:0] ch, input logic [7:0] pat, input int reps);
        for (int i = 0; i < reps * 8; i++)
        begin
            @(negedge ref_clk);
            rxV = ch;
            rxD = pat[7 - i % 8] ? ch : 8'h00;
        end
        @(negedge ref_clk);
        rxV = 8'h00;
        repeat (4) @(negedge ref_clk);
    endtask : send

    // read answer stands from the read edge on, checked at the falling edge after it
    always @(posedge ref_clk) rdLate <= hostRdEn;
    always @(negedge ref_clk)
        if (rdLate)
            check("read", rdData, rdQ.pop_front());

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial
    begin
        #200000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        wr(5'h1F, 8'hAA);
        check("ptr", bankPtr, 8'hAA);
        for (int i = 0; i < 10; i++) rd(5'(i), 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            for (int i = 0; i < 10; i++)
            begin
                lfsr = nxt(lfsr);
                rg[i] = (i == 8) ? (lfsr[7:0] & 8'h3F) : lfsr[7:0];
                wr(5'(i), rg[i]);
            end
            txNeg = lfsr[15:8];
            repeat (6) @(negedge ref_clk);
            check("cfg", cfg, expCfg(8'h00));
            for (int i = 0; i < 10; i++) rd(5'(i), rg[i]);
        end
        // primary bank hides and protects the expanded registers
        wr(5'h1F, 8'h00);
        check("ptrPrim", bankPtr, 8'h00);
        rd(5'h1F, 8'h00);
        wr(5'h03, ~rg[3]);
        rd(5'h03, 8'h00);
        wr(5'h1F, 8'hAA);
        rd(5'h1F, 8'hAA);
        rd(5'h03, rg[3]);
        wr(5'h15, 8'h5A);
        rd(5'h15, 8'h00);
        // stuck transmit clocks on channels 0 and 3 power only those transmitters down
        txClk = 8'hF6;
        repeat (TXLOW + 8) @(negedge ref_clk);
        check("txStuck", cfg, expCfg(8'h09));
        txClk = 8'hFF;
        repeat (6) @(negedge ref_clk);
        check("txFree", cfg, expCfg(8'h00));
        // detector off, then full-length mismatch, then 6-bit lengths that match
        wr(5'h08, 8'h13);
        wr(5'h09, 8'hA6); // 6-bit code 101001 with its two msbs repeated below
        send(8'h24, 8'hA5, 5);
        check("off", lds, 8'h00);
        wr(5'h08, 8'h3F);
        send(8'h24, 8'hA5, 5);
        check("len8", lds, 8'h00);
        wr(5'h08, 8'h35);
        send(8'h24, 8'hA5, 5);
        check("act", lds, 8'h24);
        check("auto", alb, 8'h24);
        check("irqSet", lis, 8'h04);
        @(negedge ref_clk);
        irqClr = 1'b1;
        @(negedge ref_clk);
        irqClr = 1'b0;
        @(negedge ref_clk);
        check("irqClr", lis, 8'h00);
        send(8'h24, 8'h3C, 5);
        check("deact", lds, 8'h00);
        check("irqAgain", lis, 8'h04);
        repeat (3) @(negedge ref_clk);
        report_and_stop();
    end
endmodule : tb
